// ### hw/fault_flags.v
`timescale 1ns/100ps
// sticky flags; a set in the clear cycle wins
module fault_flags #(
  parameter W = 8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // flag control
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] flag_r
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= {W{1'b0}};
    end else begin
      flag_r <= (flag_r & ~clr) | set;
    end
  end
endmodule // fault_flags

// ### hw/fault_status_and_history_manager.v
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`include "fault_status_regs.vh"
// How it works
// - any alarm opens drive ready, all but estop give servo-off; only reset clears, estop clears on release
// - warning opens warning output; cleared by clear input, clear command or reset
// - limit opens only its direction output, stops motor, refuses that direction
// - outputs closed normally, open on fault by default; polarity selectable
// - indicator shows fault codes only in fault display mode, else io state
// - tell query lists every active alarm and warning, several at once
// - tell query with nothing active yields no entries
// - advance key gives next entry, quit key ends listing
// - listing order is by fault index, not by occurrence
// - history keeps up to 32 records
// - when full, oldest record drops and the new one is appended
// - record 1 is the newest, counting toward older ones
// - record holds code, sub code, elapsed time and power-on count
// - history query first shows elapsed time and power count, then records
// - overtravel, estop, ram and undervoltage never recorded; cpu, rom on qualifier
// - overtravel and estop hold servo-lock; ram error, undervoltage give servo-off
// - home reset appends a home event record
// - each recorded alarm pulses a save strobe to non-volatile storage
module fault_status_and_history_manager #(
  parameter TICKS_PER_SEC = `TIME_NS_PER_SEC / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // fault sources
  input wire [5:0] alarm_in,
  input wire cpu_error_in,
  input wire rom_error_in,
  input wire cpu_rom_record_in,
  input wire ram_error_in,
  input wire undervoltage_in,
  input wire emergency_stop_in,
  input wire hw_plus_limit_in,
  input wire hw_minus_limit_in,
  input wire sw_plus_limit_in,
  input wire sw_minus_limit_in,
  input wire [2:0] warning_in,
  input wire [7:0] sub_code_in,
  input wire fault_clear_in,
  input wire home_return_done_in,
  input wire [15:0] power_on_count_in,
  input wire [7:0] io_state_in,
  // motion requests
  input wire move_plus_req,
  input wire move_minus_req,
  output wire move_plus_ok,
  output wire move_minus_ok,
  // status pins and motor state
  output reg drive_ready_out,
  output reg warning_out,
  output reg plus_limit_out,
  output reg minus_limit_out,
  output reg servo_off_out,
  output reg servo_lock_out,
  output reg [7:0] indicator_out,
  output reg nv_save_pulse
);
  // ****************************************
  // registers and strobes
  // ****************************************
  reg [31:0] ctrl_r;
  reg [5:0] cmd_r;
  reg [5:0] awaddr_r;
  reg [31:0] wdata_r;
  reg aw_got_r, w_got_r;
  wire [15:0] active;
  wire [5:0] alarm_lat;
  wire [2:0] warn_lat;
  wire clr_warn = fault_clear_in | cmd_r[`CMD_CLEAR];
  // ****************************************
  // fault latches
  // ****************************************
  fault_flags #(.W(6)) u_alarm (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(alarm_in),
    .clr(6'h00),
    .flag_r(alarm_lat)
  );
  fault_flags #(.W(3)) u_warn (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(warning_in),
    .clr({3{clr_warn}}),
    .flag_r(warn_lat)
  );
  reg cpu_r, rom_r, ram_r, uv_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_r <= 1'b0;
      rom_r <= 1'b0;
      ram_r <= 1'b0;
      uv_r <= 1'b0;
    end else begin
      cpu_r <= cpu_r | cpu_error_in;
      rom_r <= rom_r | rom_error_in;
      ram_r <= ram_r | ram_error_in;
      uv_r <= uv_r | undervoltage_in;
    end
  end
  // estop follows its input, so release clears it
  wire hw_ot = hw_plus_limit_in | hw_minus_limit_in;
  wire sw_ot = sw_plus_limit_in | sw_minus_limit_in;
  assign active = {warn_lat, sw_ot, hw_ot, emergency_stop_in, uv_r, ram_r, rom_r, cpu_r, alarm_lat};
  wire alarm_any = |active[`F_ESTOP:`F_ALARM_LO];
  wire plus_lim = hw_plus_limit_in | sw_plus_limit_in;
  wire minus_lim = hw_minus_limit_in | sw_minus_limit_in;
  assign move_plus_ok = move_plus_req & ~plus_lim & ~alarm_any;
  assign move_minus_ok = move_minus_req & ~minus_lim & ~alarm_any;
  // ****************************************
  // pins, motor state, indicator
  // ****************************************
  reg [3:0] first_idx;
  reg first_any;
  integer k;
  always @* begin
    first_idx = 4'h0;
    first_any = 1'b0;
    for (k = `NFAULT - 1; k >= 0; k = k - 1) begin
      if (active[k]) begin
        first_idx = k[3:0];
        first_any = 1'b1;
      end
    end
  end
  wire pol = ctrl_r[`CTRL_POL];
  wire [2:0] warn_soff = warn_lat & ctrl_r[`CTRL_WSOFF_HI:`CTRL_WSOFF_LO];
  wire soff = (|active[`F_UNDERVOLT:`F_ALARM_LO]) | (|warn_soff);
  always @(posedge aclk) begin
    if (!aresetn) begin
      drive_ready_out <= 1'b0;
      warning_out <= 1'b0;
      plus_limit_out <= 1'b0;
      minus_limit_out <= 1'b0;
      servo_off_out <= 1'b1;
      servo_lock_out <= 1'b0;
      indicator_out <= 8'h00;
    end else begin
      // high is closed; pol inverts the ready, warning and limit pins, not servo-off or servo-lock
      drive_ready_out <= ~alarm_any ^ pol;
      warning_out <= ~(|warn_lat) ^ pol;
      plus_limit_out <= ~plus_lim ^ pol;
      minus_limit_out <= ~minus_lim ^ pol;
      servo_off_out <= soff;
      servo_lock_out <= ~soff & (hw_ot | sw_ot | emergency_stop_in);
      if (ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_FAULT_DISPLAY) begin
        indicator_out <= {first_any, 3'h0, first_idx};
      end else begin
        indicator_out <= io_state_in;
      end
    end
  end
  // ****************************************
  // elapsed time since power-on
  // ****************************************
  reg [31:0] tick_r;
  reg [31:0] elapsed_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_r <= 32'h0;
      elapsed_r <= 32'h0;
    end else if (tick_r == TICKS_PER_SEC - 1) begin
      tick_r <= 32'h0;
      elapsed_r <= elapsed_r + 32'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end
  // ****************************************
  // history recording
  // ****************************************
  reg [16:0] prev_r, pend_r;
  reg [`HIST_AW-1:0] wr_ptr_r;
  reg [`HIST_CW-1:0] count_r;
  wire [16:0] recordable;
  assign recordable = {home_return_done_in | cmd_r[`CMD_ABSZERO], warn_lat, 5'h00,
    cpu_rom_record_in & rom_r, cpu_rom_record_in & cpu_r, alarm_lat};
  wire [16:0] rise = recordable & ~prev_r;
  reg [4:0] wr_idx;
  reg wr_any;
  integer j;
  always @* begin
    wr_idx = 5'h0;
    wr_any = 1'b0;
    for (j = 16; j >= 0; j = j - 1) begin
      if (pend_r[j]) begin
        wr_idx = j[4:0];
        wr_any = 1'b1;
      end
    end
  end
  wire [7:0] wr_code = (wr_idx == `EVT_HOME) ? `EVT_HOME_CODE : {3'h0, wr_idx};
  wire [`REC_W-1:0] wr_rec = {wr_code, sub_code_in, elapsed_r, power_on_count_in};
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 17'h0;
      pend_r <= 17'h0;
      wr_ptr_r <= {`HIST_AW{1'b0}};
      count_r <= {`HIST_CW{1'b0}};
      nv_save_pulse <= 1'b0;
    end else begin
      // one record per cycle; simultaneous arrivals wait in pend_r
      prev_r <= recordable;
      pend_r <= (pend_r & ~(wr_any ? (17'h1 << wr_idx) : 17'h0)) | rise;
      nv_save_pulse <= wr_any & (wr_idx <= `F_ROM);
      if (wr_any) begin
        wr_ptr_r <= wr_ptr_r + 5'h1;
        if (count_r != `HIST_DEPTH) begin
          count_r <= count_r + 6'h1;
        end
      end
    end
  end
  // ****************************************
  // listing sequencer
  // ****************************************
  reg [1:0] state_r;
  reg [3:0] cur_r;
  reg [`HIST_CW-1:0] rec_n_r;
  wire [`REC_W-1:0] rd_rec;
  wire [`HIST_AW-1:0] rd_addr = wr_ptr_r - rec_n_r[`HIST_AW-1:0];
  history_mem #(.W(`REC_W), .D(`HIST_DEPTH), .AW(`HIST_AW)) u_mem (
    .aclk(aclk),
    .we(wr_any),
    .waddr(wr_ptr_r),
    .wdata(wr_rec),
    .raddr(rd_addr),
    .rdata(rd_rec)
  );
  reg [3:0] nxt_idx;
  reg nxt_any;
  reg [4:0] from;
  integer i;
  always @* begin
    from = cmd_r[`CMD_TELL] ? 5'h0 : {1'b0, cur_r} + 5'h1;
    nxt_idx = 4'h0;
    nxt_any = 1'b0;
    for (i = `NFAULT - 1; i >= 0; i = i - 1) begin
      if (active[i] && i >= from) begin
        nxt_idx = i[3:0];
        nxt_any = 1'b1;
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= `ST_IDLE;
      cur_r <= 4'h0;
      rec_n_r <= {`HIST_CW{1'b0}};
    end else if (cmd_r[`CMD_QUIT]) begin
      state_r <= `ST_IDLE;
    end else if (cmd_r[`CMD_TELL] || (state_r == `ST_TELL && cmd_r[`CMD_ADVANCE])) begin
      cur_r <= nxt_idx;
      state_r <= nxt_any ? `ST_TELL : `ST_IDLE;
    end else if (cmd_r[`CMD_HIST]) begin
      state_r <= `ST_HEAD;
      rec_n_r <= {`HIST_CW{1'b0}};
    end else if (cmd_r[`CMD_ADVANCE]) begin
      case (state_r)
        `ST_HEAD, `ST_HREC: begin
          if (rec_n_r < count_r) begin
            rec_n_r <= rec_n_r + 6'h1;
            state_r <= `ST_HREC;
          end else begin
            state_r <= `ST_IDLE;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end
  // query word: valid, kind, record number, code, sub code
  reg [31:0] q_word, q_time, q_pwr;
  always @* begin
    q_word = 32'h0;
    q_time = 32'h0;
    q_pwr = 32'h0;
    case (state_r)
      `ST_TELL: begin
        q_word = {1'b1, 3'h1, 12'h0, 4'h0, cur_r, 8'h0};
      end
      `ST_HEAD: begin
        q_word = {1'b1, 3'h2, 28'h0};
        q_time = elapsed_r;
        q_pwr = {16'h0, power_on_count_in};
      end
      `ST_HREC: begin
        q_word = {1'b1, 3'h3, 2'h0, rec_n_r, rd_rec[63:48], 2'h0, 2'h0};
        q_time = rd_rec[47:16];
        q_pwr = {16'h0, rd_rec[15:0]};
      end
      default: begin
        q_word = 32'h0;
      end
    endcase
  end
  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 6'h0;
      wdata_r <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_r <= `CTRL_RESET;
      cmd_r <= 6'h0;
    end else begin
      cmd_r <= 6'h0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // write strobes are ignored; a control write takes the whole word, a command write only bits 5:0
        if (awaddr_r[5:2] == `OFS_CTRL >> 2) begin
          ctrl_r <= wdata_r;
        end else if (awaddr_r[5:2] == `OFS_CMD >> 2) begin
          cmd_r <= wdata_r[5:0];
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[5:2], 2'h0})
        `OFS_CTRL: s_axi_rdata <= ctrl_r;
        `OFS_STATUS: s_axi_rdata <= {11'h0, state_r, servo_lock_out, servo_off_out, alarm_any, active};
        `OFS_CMD: s_axi_rdata <= 32'h0;
        `OFS_QUERY: s_axi_rdata <= q_word;
        `OFS_QTIME: s_axi_rdata <= q_time;
        `OFS_QPWR: s_axi_rdata <= q_pwr;
        `OFS_ELAPSED: s_axi_rdata <= elapsed_r;
        `OFS_HCOUNT: s_axi_rdata <= {26'h0, count_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // fault_status_and_history_manager

// ### hw/fault_status_regs.vh
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 6'h00
`define OFS_STATUS 6'h04
`define OFS_CMD 6'h08
`define OFS_QUERY 6'h0c
`define OFS_QTIME 6'h10
`define OFS_QPWR 6'h14
`define OFS_ELAPSED 6'h18
`define OFS_HCOUNT 6'h1c
// ****************************************
// control fields and reset value
// ****************************************
`define CTRL_POL 0
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 6
`define CTRL_WSOFF_LO 8
`define CTRL_WSOFF_HI 10
`define CTRL_RESET 32'h0000_0000
`define MODE_FAULT_DISPLAY 3'h0
// ****************************************
// command bits, one-cycle strobes
// ****************************************
`define CMD_CLEAR 0
`define CMD_TELL 1
`define CMD_HIST 2
`define CMD_ADVANCE 3
`define CMD_QUIT 4
`define CMD_ABSZERO 5
// ****************************************
// active fault vector layout
// ****************************************
`define NFAULT 16
`define F_ALARM_LO 0
`define F_ALARM_HI 5
`define F_CPU 6
`define F_ROM 7
`define F_RAM 8
`define F_UNDERVOLT 9
`define F_ESTOP 10
`define F_HW_OT 11
`define F_SW_OT 12
`define F_WARN_LO 13
`define F_WARN_HI 15
`define EVT_HOME 16
`define EVT_HOME_CODE 8'h1f
// ****************************************
// history record layout and timing
// ****************************************
`define REC_W 64
`define HIST_DEPTH 32
`define HIST_AW 5
`define HIST_CW 6
`define TIME_NS_PER_SEC 1000000000
`define CLK_PERIOD_NS 20
`define ST_IDLE 2'h0
`define ST_TELL 2'h1
`define ST_HEAD 2'h2
`define ST_HREC 2'h3
`endif

// ### hw/history_mem.v
`timescale 1ns/100ps
// record store, read data registered
module history_mem #(
  parameter W = 64,
  parameter D = 32,
  parameter AW = 5
) (
  // clock
  input wire aclk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  // read port
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:D-1];
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // history_mem

// ### testbench/fsh_chk_sva.sv
`timescale 1ns/100ps
// ****************************************
// fault status checker
// ****************************************
module fsh_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // fault sources
  input wire [5:0] alarm_in,
  input wire ram_error_in,
  input wire undervoltage_in,
  input wire emergency_stop_in,
  input wire hw_plus_limit_in,
  input wire hw_minus_limit_in,
  input wire sw_minus_limit_in,
  // motion and status
  input wire move_plus_ok,
  input wire move_minus_ok,
  input wire plus_limit_out,
  input wire minus_limit_out,
  input wire servo_off_out,
  input wire servo_lock_out,
  input wire nv_save_pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  alarm_off_a: assert property (|alarm_in |-> ##[1:3] (servo_off_out && !move_minus_ok))
    else $error("alarm did not stop the motor");
  limit_dir_a: assert property ($rose(hw_plus_limit_in) |-> ##[1:3] (plus_limit_out != minus_limit_out))
    else $error("limit pins not split by direction");
  plus_refuse_a: assert property (hw_plus_limit_in [*3] |-> !move_plus_ok)
    else $error("motion into plus limit accepted");
  minus_refuse_a: assert property (sw_minus_limit_in [*3] |-> !move_minus_ok)
    else $error("motion into minus limit accepted");
  estop_lock_a: assert property (emergency_stop_in [*3] |-> servo_lock_out && !move_plus_ok)
    else $error("estop without servo lock");
  limit_lock_a: assert property (hw_minus_limit_in [*3] ##0 !servo_off_out |-> servo_lock_out)
    else $error("limit without servo lock");
  power_off_a: assert property ((ram_error_in || undervoltage_in) |-> ##[1:3] servo_off_out)
    else $error("ram or supply fault without servo off");
  save_pulse_a: assert property (nv_save_pulse |=> !nv_save_pulse)
    else $error("save strobe longer than one cycle");
endmodule // fsh_chk

bind fault_status_and_history_manager fsh_chk u_chk (.*);

// ### testbench/motion_master.sv
`timescale 1ns/100ps
// ****************************************
// master controller model
// ****************************************
module motion_master (
  // clock
  input wire aclk,
  // wanted directions, plus then minus
  input wire [1:0] want,
  // drive status pins
  input wire plus_limit_out,
  input wire minus_limit_out,
  // motion requests
  output logic move_plus_req,
  output logic move_minus_req
);
  // default polarity only: an open pin reads low
  // an open limit pin requests the other direction, backing away from that limit
  initial begin
    move_plus_req = 1'b0;
    move_minus_req = 1'b0;
  end
  always @(posedge aclk) begin
    move_plus_req <= want[1] || !minus_limit_out;
    move_minus_req <= want[0] || !plus_limit_out;
  end
endmodule // motion_master

// ### testbench/tb_fault_status_and_history_manager.sv
`timescale 1ns/100ps
`include "fault_status_regs.vh"
// ****************************************
// fault status bench
// ****************************************
module tb_fault_status_and_history_manager;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr, alarm_in;
  logic [31:0] s_axi_wdata, q;
  logic [3:0] s_axi_wstrb;
  logic cpu_error_in, rom_error_in, cpu_rom_record_in, ram_error_in, undervoltage_in, emergency_stop_in;
  logic hw_plus_limit_in, hw_minus_limit_in, sw_plus_limit_in, sw_minus_limit_in, fault_clear_in, home_return_done_in;
  logic [2:0] warning_in;
  logic [7:0] sub_code_in, io_state_in;
  logic [15:0] power_on_count_in, m;
  logic [1:0] want, rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, move_plus_req, move_minus_req;
  wire move_plus_ok, move_minus_ok, drive_ready_out, warning_out, plus_limit_out, minus_limit_out;
  wire servo_off_out, servo_lock_out, nv_save_pulse;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] indicator_out;
  int bad_count, cmp_count;
  int saves;
  // counts save strobes, one per recorded alarm
  always @(posedge aclk) begin
    if (nv_save_pulse) saves <= saves + 1;
  end
  // fault inputs, then pins ready warn plus minus off lock pok mok, then fill count
  logic [25:0] rows [11] = '{26'h00003cc, 26'h01001e1, 26'h20001e1, 26'h00801e0, 26'h00401e0, 26'h00201d0,
    26'h0010354, 26'h0008398, 26'h0004354, 26'h0002398, 26'h00016ce};
  fault_status_and_history_manager #(.TICKS_PER_SEC(10)) dut (.*);
  motion_master model (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task rst;
    {alarm_in, ram_error_in, undervoltage_in, emergency_stop_in, hw_plus_limit_in, hw_minus_limit_in,
      sw_plus_limit_in, sw_minus_limit_in, warning_in} <= 16'h0000;
    aresetn <= 1'b0;
    tick(16);
    aresetn <= 1'b1;
  endtask
  // ready is looked at just before the edge that takes the item
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic ka, kw, da, dw;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {da, dw} = 2'h0;
    while (!(da && dw)) begin
      @(negedge aclk);
      ka = s_axi_awvalid && s_axi_awready;
      kw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ka) begin
        s_axi_awvalid <= 1'b0;
        da = 1'b1;
      end
      if (kw) begin
        s_axi_wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    ka = 1'b0;
    while (!ka) begin
      @(negedge aclk);
      ka = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [5:0] a);
    logic k;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    k = 1'b0;
    while (!k) begin
      @(negedge aclk);
      k = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    k = 1'b0;
    while (!k) begin
      @(negedge aclk);
      k = s_axi_rvalid;
      {q, rsp} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask
  // record data lands a cycle after the query fields
  task adv;
    wr(`OFS_CMD, 1 << `CMD_ADVANCE);
    tick(2);
  endtask
  initial begin
    #1000000;
    bad_count++;
    results;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    {cpu_error_in, rom_error_in, cpu_rom_record_in, fault_clear_in, home_return_done_in, sub_code_in} = 13'h0;
    {s_axi_wstrb, io_state_in, power_on_count_in, want} = {4'hf, 8'h5a, 16'h0007, 2'h3};
    rst;
    @(negedge aclk);
    chk("reset pins", 14'h0200, {drive_ready_out, warning_out, plus_limit_out, minus_limit_out, servo_off_out,
      servo_lock_out, indicator_out});
    rd(`OFS_CTRL);
    chk("ctrl reset", `CTRL_RESET, q);
    for (int i = 0; i < 11; i++) begin
      rst;
      {alarm_in, ram_error_in, undervoltage_in, emergency_stop_in, hw_plus_limit_in, hw_minus_limit_in,
        sw_plus_limit_in, sw_minus_limit_in, warning_in} <= rows[i][25:10];
      tick(5);
      @(negedge aclk);
      chk("pins", rows[i][9:2], {drive_ready_out, warning_out, plus_limit_out, minus_limit_out, servo_off_out,
        servo_lock_out, move_plus_ok, move_minus_ok});
      rd(`OFS_HCOUNT);
      chk("fill count", rows[i][1:0], q);
    end
    chk("save strobes", 2, saves);
    rst;
    wr(`OFS_CMD, 1 << `CMD_TELL);
    rd(`OFS_QUERY);
    chk("empty listing", 0, q[31]);
    {emergency_stop_in, hw_plus_limit_in} <= 2'h3;
    tick(4);
    wr(`OFS_CMD, 1 << `CMD_TELL);
    m = 16'h0000;
    repeat (2) begin
      rd(`OFS_QUERY);
      chk("tell entry", 4'h9, q[31:28]);
      m[q[11:8]] = 1'b1;
      wr(`OFS_CMD, 1 << `CMD_ADVANCE);
    end
    chk("listed set", 16'h0c00, m);
    rd(`OFS_QUERY);
    chk("listing end", 0, q[31]);
    @(negedge aclk);
    chk("fault view", 8'h8a, indicator_out);
    wr(`OFS_CMD, 1 << `CMD_TELL);
    wr(`OFS_CMD, 1 << `CMD_QUIT);
    rd(`OFS_QUERY);
    chk("quit", 0, q[31]);
    {emergency_stop_in, want} <= 3'h0;
    tick(4);
    @(negedge aclk);
    chk("estop release", 2'h3, {drive_ready_out, move_minus_ok});
    @(posedge aclk);
    {hw_plus_limit_in, want} <= 3'h3;
    wr(`OFS_CTRL, 32'h0000_0010);
    tick(3);
    @(negedge aclk);
    chk("io view", io_state_in, indicator_out);
    wr(`OFS_CTRL, 32'h0000_0001);
    tick(3);
    @(negedge aclk);
    chk("inverted pins", 0, {drive_ready_out, warning_out, plus_limit_out, minus_limit_out});
    rd(`OFS_CTRL);
    chk("ctrl rw", 1, q);
    wr(`OFS_CTRL, 32'h0000_0200);
    warning_in <= 3'h2;
    tick(1);
    warning_in <= 3'h0;
    tick(2);
    @(negedge aclk);
    chk("warning stop", 1, servo_off_out);
    wr(`OFS_CMD, 1 << `CMD_CLEAR);
    tick(3);
    @(negedge aclk);
    chk("cmd clear", 1, warning_out);
    @(posedge aclk);
    warning_in <= 3'h4;
    tick(1);
    {warning_in, fault_clear_in} <= 4'h1;
    tick(1);
    fault_clear_in <= 1'b0;
    tick(3);
    @(negedge aclk);
    chk("input clear", 1, warning_out);
    rd(6'h20);
    chk("unmapped read", 34'h2, {q, rsp});
    wr(6'h24, 32'h0000_0001);
    chk("unmapped write", 2, rsp);
    {cpu_error_in, cpu_rom_record_in} <= 2'h3;
    tick(5);
    chk("cpu save", 3, saves);
    {cpu_error_in, cpu_rom_record_in} <= 2'h0;
    rst;
    sub_code_in <= 8'h01;
    wr(`OFS_CMD, 1 << `CMD_ABSZERO);
    for (int i = 2; i < 34; i++) begin
      @(posedge aclk);
      {sub_code_in, home_return_done_in} <= {i[7:0], 1'b1};
      tick(1);
      home_return_done_in <= 1'b0;
      tick(2);
    end
    rd(`OFS_HCOUNT);
    chk("full count", 32, q);
    power_on_count_in <= 16'h0009;
    wr(`OFS_CMD, 1 << `CMD_HIST);
    rd(`OFS_QUERY);
    chk("head", 4'ha, q[31:28]);
    rd(`OFS_QPWR);
    chk("head power", 16'h0009, q);
    adv;
    rd(`OFS_QUERY);
    chk("newest", {4'hb, 6'h01, 8'h1f, 8'h21}, {q[31:28], q[25:4]});
    rd(`OFS_QPWR);
    chk("record power", 16'h0007, q);
    repeat (31) adv;
    rd(`OFS_QUERY);
    chk("oldest", {4'hb, 6'h20, 8'h1f, 8'h02}, {q[31:28], q[25:4]});
    adv;
    rd(`OFS_QUERY);
    chk("history end", 0, q[31]);
    results;
  end
endmodule // tb_fault_status_and_history_manager
